// file: logic/csb_defines.svh
// Purpose: Shared constants for the bus sideband block
// Assumes: One 40 MHz bus clock for both ends
// Notes: Offsets none; sizes, counts and reset values only
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CSB_DATA_W 64
`define CSB_LINES 8
`define CSB_IDX_W 3

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CSB_BIST_CYC 5'h10
`define CSB_SNP_WAIT 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSB_IRQ_CTRL_RST 1'b1
`define CSB_PIN_IDLE 1'b1

`endif

// file: logic/csb_pkg.sv
// Purpose: Types shared by both ends
// Assumes: csb_defines.svh holds the numbers
// Notes: Nothing here is imported; use csb_pkg::name
`include "csb_defines.svh"
package csb_pkg;
	// Flush sequencer states, Gray along the usual path
	typedef enum logic [1:0] {
		CSB_FL_IDLE = 2'h0,
		CSB_FL_WB = 2'h1,
		CSB_FL_INV = 2'h3,
		CSB_FL_ACK = 2'h2
	} csb_flush_e;
	typedef logic [`CSB_DATA_W-1:0] csb_data_t;
	typedef logic [`CSB_IDX_W-1:0] csb_idx_t;
endpackage

// file: logic/csb_if.sv
// Purpose: Bus sideband pins between the processor and core logic
// Assumes: Shared pins are open drain, pulled high when idle
// Notes: Resolved levels are worked out here from the enables
`timescale 1ns/1ps
`include "csb_defines.svh"
interface csb_if;
	// ----------------------------------------
	// Shared two-way pins
	// ----------------------------------------
	logic dvs_dev_o; // Data strobe, processor drive value
	logic dvs_dev_oe; // Processor drives strobe
	logic dvs_agt_o; // Data strobe, agent drive value
	logic dvs_agt_oe; // Agent drives strobe
	logic data_valid_strobe_n; // Resolved strobe level
	csb_pkg::csb_data_t dat_dev_o; // Data, processor drive value
	logic dat_dev_oe; // Processor drives data
	csb_pkg::csb_data_t dat_agt_o; // Data, agent drive value
	logic dat_agt_oe; // Agent drives data
	csb_pkg::csb_data_t data_bus_n; // Resolved data level
	// ----------------------------------------
	// Processor outputs
	// ----------------------------------------
	logic snoop_hit_result_n;
	logic snoop_modified_result_n;
	logic atomic_seq_n;
	logic float_fault_out_n;
	logic internal_fault_out_n;
	logic flush_ack_txn; // One-cycle flush acknowledge
	logic shutdown_txn; // One-cycle shutdown
	// ----------------------------------------
	// Agent outputs
	// ----------------------------------------
	logic cache_flush_req_n;
	logic numeric_fault_ignore_n;
	logic warm_init_n;
	logic bus_fault_restart_n;
	logic [1:0] local_irq_pins;
	logic target_ready_strobe_n;
	logic priority_agent_request_n;
	logic snoop_probe; // One-cycle snoop request
	csb_pkg::csb_idx_t snoop_idx;

	// Wired-AND: low whenever any end pulls low
	assign data_valid_strobe_n = ~((dvs_dev_oe & ~dvs_dev_o) |
		(dvs_agt_oe & ~dvs_agt_o));
	// Data: one driver at a time, pull-ups otherwise
	assign data_bus_n = dat_dev_oe ? dat_dev_o :
		(dat_agt_oe ? dat_agt_o : '1);

	modport dev (
		output dvs_dev_o, dvs_dev_oe, dat_dev_o, dat_dev_oe,
		output snoop_hit_result_n, snoop_modified_result_n,
		output atomic_seq_n, float_fault_out_n, internal_fault_out_n,
		output flush_ack_txn, shutdown_txn,
		input data_valid_strobe_n, data_bus_n,
		input cache_flush_req_n, numeric_fault_ignore_n, warm_init_n,
		input bus_fault_restart_n, local_irq_pins, target_ready_strobe_n,
		input priority_agent_request_n, snoop_probe, snoop_idx
	);
	modport agt (
		output dvs_agt_o, dvs_agt_oe, dat_agt_o, dat_agt_oe,
		output cache_flush_req_n, numeric_fault_ignore_n, warm_init_n,
		output bus_fault_restart_n, local_irq_pins, target_ready_strobe_n,
		output priority_agent_request_n, snoop_probe, snoop_idx,
		input data_valid_strobe_n, data_bus_n,
		input snoop_hit_result_n, snoop_modified_result_n,
		input atomic_seq_n, float_fault_out_n, internal_fault_out_n,
		input flush_ack_txn, shutdown_txn
	);
endinterface

// file: logic/csb_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pins
// Assumes: Destination clock is ref_clk
// Notes: No reset, so it tracks the pin through reset
`timescale 1ns/1ps
module csb_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // First stage, read only by q

	// Without reset the strap value is already settled at release
	always_ff @(posedge ref_clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule

// file: logic/csb_device.sv
// Purpose: Processor end of the bus sideband and control pins
// Assumes: Bus pins are synchronous to ref_clk; sideband inputs are not
// Notes: Cache is a small line store to exercise flush and snoop
`timescale 1ns/1ps
`include "csb_defines.svh"

// How it works
// - Driver asserts strobe on each data transfer
// - Strobe may drop for idle clocks
// - Unmasked float error drives float fault low
// - Flush writes back dirty lines, then invalidates
// - Flush acknowledge issued after invalidation
// - No allocation while flush request held
// - Agent sets flush valid by target ready
// - Flush pin sampled at reset release
// - Both snoop results low means stall
// - Internal fault held until reset/restart/init
// - Internal fault comes with shutdown transaction
// - Ignore input decides float exception
// - Native mode bit disables ignore input
// - Agent sets ignore valid by target ready
// - Warm init resets integer state only
// - Restart uses configured reset vector
// - Snoops answered during warm init
// - Init active at reset release runs self-test
// - Controller off: pins become irq and nmi
// - Controller enabled after reset
// - Lock held across whole locked sequence
// - Priority agent waits for lock release
// - Data bus is 64 bits, shared
module csb_device (
	input wire logic ref_clk,
	input wire logic sys_rst,
	csb_if.dev bus,
	input wire logic fill_valid,
	input wire logic [`CSB_IDX_W-1:0] fill_idx,
	input wire logic [`CSB_DATA_W-1:0] fill_data,
	input wire logic store_valid,
	input wire logic [`CSB_IDX_W-1:0] store_idx,
	input wire logic [`CSB_DATA_W-1:0] store_data,
	input wire logic wb_pause,
	input wire logic fp_err_pending,
	input wire logic fp_noncontrol_issue,
	input wire logic native_numeric_fault_mode,
	input wire logic internal_error,
	input wire logic lock_hold,
	input wire logic irq_ctrl_wr,
	input wire logic irq_ctrl_en_val,
	output logic fp_exception,
	output logic int_regs_reset,
	output logic reset_vector_sel,
	output logic bist_running,
	output logic maskable_irq,
	output logic nmi_req,
	output logic [1:0] local_irq_lvl,
	output logic flush_busy,
	output logic rx_valid,
	output logic [`CSB_DATA_W-1:0] rx_data
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] sy; // {irq1, irq0, init_n, ignore_n, flush_n}
	logic flush_req; // Flush requested, true high
	logic ign_req; // Ignore numeric error, true high
	logic init_req; // Warm init, true high

	csb_sync #(.W(5)) u_sync (
		.ref_clk(ref_clk),
		.d({bus.local_irq_pins, bus.warm_init_n,
			bus.numeric_fault_ignore_n, bus.cache_flush_req_n}),
		.q(sy)
	);
	assign flush_req = ~sy[0];
	assign ign_req = ~sy[1];
	assign init_req = ~sy[2];

	// ----------------------------------------
	// State
	// ----------------------------------------
	csb_pkg::csb_flush_e fl_r; // Flush sequencer
	csb_pkg::csb_idx_t wb_idx_r; // Line being written back
	logic [`CSB_LINES-1:0] line_v_r; // Line valid
	logic [`CSB_LINES-1:0] line_d_r; // Line modified
	csb_pkg::csb_data_t line_mem [`CSB_LINES]; // Line data, no reset
	logic cfg_done_r; // Straps captured
	logic [4:0] bist_cnt_r; // Self-test cycles left
	logic init_d_r; // Init, last cycle
	logic irq_ctrl_en_r; // Local controller enabled
	logic internal_fault_out_n_r; // Internal fault pin, low once latched
	logic snp_pend_r; // Snoop waiting for answer
	csb_pkg::csb_idx_t snp_idx_r; // Snoop line
	logic dvs_oe_r; // Strobe pulled low
	logic dat_oe_r; // Data driven
	csb_pkg::csb_data_t dat_o_r; // Data drive value
	logic hit_n_r, snoop_modified_result_n_r, lock_n_r, float_fault_out_n_r, ack_r, shut_r;
	logic alloc_ok; // Cache may take new data

	// Stores are also held off, else a line could turn dirty mid-scan
	assign alloc_ok = ~flush_req && (fl_r == csb_pkg::CSB_FL_IDLE);

	// ----------------------------------------
	// Power-on straps and self-test
	// ----------------------------------------
	// Sync flops run through reset, so the first edge after release
	// sees the pin level held across the release
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_done_r <= 1'b0;
			reset_vector_sel <= 1'b0;
			bist_cnt_r <= 5'h00;
		end else if (!cfg_done_r) begin
			cfg_done_r <= 1'b1;
			reset_vector_sel <= flush_req;
			bist_cnt_r <= init_req ? `CSB_BIST_CYC : 5'h00;
		end else if (bist_cnt_r != 5'h00) begin
			bist_cnt_r <= bist_cnt_r - 5'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bist_running <= 1'b0;
		end else begin
			bist_running <= (bist_cnt_r > 5'h01) ||
				(!cfg_done_r && init_req);
		end
	end

	// ----------------------------------------
	// Warm init
	// ----------------------------------------
	// Pulse on assertion; cache arrays and flush state are left alone
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_d_r <= 1'b0;
			int_regs_reset <= 1'b0;
		end else begin
			init_d_r <= init_req;
			int_regs_reset <= init_req & ~init_d_r & cfg_done_r;
		end
	end

	// ----------------------------------------
	// Flush sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fl_r <= csb_pkg::CSB_FL_IDLE;
			wb_idx_r <= '0;
		end else begin
			unique case (fl_r)
				csb_pkg::CSB_FL_IDLE: begin
					wb_idx_r <= '0;
					if (flush_req) begin
						fl_r <= csb_pkg::CSB_FL_WB;
					end
				end
				csb_pkg::CSB_FL_WB: begin
					// Hold on a dirty line while paused
					if (!(line_d_r[wb_idx_r] && wb_pause)) begin
						wb_idx_r <= wb_idx_r + 3'h1;
						if (wb_idx_r == 3'h7) begin
							fl_r <= csb_pkg::CSB_FL_INV;
						end
					end
				end
				csb_pkg::CSB_FL_INV: begin
					fl_r <= csb_pkg::CSB_FL_ACK;
				end
				csb_pkg::CSB_FL_ACK: begin
					// Wait for release so one request flushes once
					if (!flush_req) begin
						fl_r <= csb_pkg::CSB_FL_IDLE;
					end
				end
			endcase
		end
	end

	// Acknowledge only after the invalidate step
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
			flush_busy <= 1'b0;
		end else begin
			ack_r <= (fl_r == csb_pkg::CSB_FL_INV);
			flush_busy <= (fl_r != csb_pkg::CSB_FL_IDLE) || flush_req;
		end
	end

	// ----------------------------------------
	// Line flags and data
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_v_r <= '0;
			line_d_r <= '0;
		end else if (fl_r == csb_pkg::CSB_FL_INV) begin
			line_v_r <= '0;
			line_d_r <= '0;
		end else if (fl_r == csb_pkg::CSB_FL_WB) begin
			if (!wb_pause) begin
				line_d_r[wb_idx_r] <= 1'b0;
			end
		end else if (alloc_ok) begin
			if (fill_valid) begin
				line_v_r[fill_idx] <= 1'b1;
				line_d_r[fill_idx] <= 1'b0;
			end
			if (store_valid && line_v_r[store_idx]) begin
				line_d_r[store_idx] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (alloc_ok && fill_valid) begin
			line_mem[fill_idx] <= fill_data;
		end
		if (alloc_ok && store_valid && line_v_r[store_idx]) begin
			line_mem[store_idx] <= store_data;
		end
	end

	// ----------------------------------------
	// Data bus drive and receive
	// ----------------------------------------
	// Strobe only with a dirty line; pause or clean lines give idles
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dvs_oe_r <= 1'b0;
			dat_oe_r <= 1'b0;
			dat_o_r <= '1;
		end else begin
			dvs_oe_r <= (fl_r == csb_pkg::CSB_FL_WB) &&
				line_d_r[wb_idx_r] && !wb_pause;
			dat_oe_r <= (fl_r == csb_pkg::CSB_FL_WB);
			dat_o_r <= ~line_mem[wb_idx_r];
		end
	end
	assign bus.dvs_dev_o = 1'b0;
	assign bus.dvs_dev_oe = dvs_oe_r;
	assign bus.dat_dev_o = dat_o_r;
	assign bus.dat_dev_oe = dat_oe_r;

	// Data is taken only in strobed cycles the agent drives
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= '0;
		end else begin
			rx_valid <= ~bus.data_valid_strobe_n & ~dvs_oe_r;
			if (~bus.data_valid_strobe_n & ~dvs_oe_r) begin
				rx_data <= ~bus.data_bus_n;
			end
		end
	end

	// ----------------------------------------
	// Snoop answers
	// ----------------------------------------
	// Mid write-back a line may be half done, so stall instead
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snp_pend_r <= 1'b0;
			snp_idx_r <= '0;
			hit_n_r <= `CSB_PIN_IDLE;
			snoop_modified_result_n_r <= `CSB_PIN_IDLE;
		end else if (bus.snoop_probe) begin
			snp_pend_r <= 1'b1;
			snp_idx_r <= bus.snoop_idx;
			hit_n_r <= `CSB_PIN_IDLE;
			snoop_modified_result_n_r <= `CSB_PIN_IDLE;
		end else if (snp_pend_r && fl_r == csb_pkg::CSB_FL_WB) begin
			hit_n_r <= 1'b0;
			snoop_modified_result_n_r <= 1'b0;
		end else if (snp_pend_r) begin
			snp_pend_r <= 1'b0;
			// Modified shows alone; both low is kept for stalls
			hit_n_r <= ~(line_v_r[snp_idx_r] & ~line_d_r[snp_idx_r]);
			snoop_modified_result_n_r <= ~(line_v_r[snp_idx_r] & line_d_r[snp_idx_r]);
		end else begin
			hit_n_r <= `CSB_PIN_IDLE;
			snoop_modified_result_n_r <= `CSB_PIN_IDLE;
		end
	end

	// ----------------------------------------
	// Faults and float exception
	// ----------------------------------------
	// A new error wins over a same-cycle clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			internal_fault_out_n_r <= `CSB_PIN_IDLE;
			shut_r <= 1'b0;
		end else begin
			if (internal_error) begin
				internal_fault_out_n_r <= 1'b0;
			end else if (~bus.bus_fault_restart_n || init_req) begin
				internal_fault_out_n_r <= 1'b1;
			end
			shut_r <= internal_error & internal_fault_out_n_r;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			float_fault_out_n_r <= `CSB_PIN_IDLE;
			fp_exception <= 1'b0;
			lock_n_r <= `CSB_PIN_IDLE;
		end else begin
			float_fault_out_n_r <= ~fp_err_pending;
			fp_exception <= fp_noncontrol_issue & fp_err_pending &
				(native_numeric_fault_mode | ~ign_req);
			lock_n_r <= ~lock_hold;
		end
	end

	// ----------------------------------------
	// Local interrupt pins
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ctrl_en_r <= `CSB_IRQ_CTRL_RST;
			maskable_irq <= 1'b0;
			nmi_req <= 1'b0;
			local_irq_lvl <= 2'h0;
		end else begin
			if (irq_ctrl_wr) begin
				irq_ctrl_en_r <= irq_ctrl_en_val;
			end
			maskable_irq <= ~irq_ctrl_en_r & sy[3];
			nmi_req <= ~irq_ctrl_en_r & sy[4];
			local_irq_lvl <= irq_ctrl_en_r ? sy[4:3] : 2'h0;
		end
	end

	assign bus.snoop_hit_result_n = hit_n_r;
	assign bus.snoop_modified_result_n = snoop_modified_result_n_r;
	assign bus.atomic_seq_n = lock_n_r;
	assign bus.float_fault_out_n = float_fault_out_n_r;
	assign bus.internal_fault_out_n = internal_fault_out_n_r;
	assign bus.flush_ack_txn = ack_r;
	assign bus.shutdown_txn = shut_r;
endmodule

// file: logic/csb_agent.sv
// Purpose: Core logic end of the bus sideband and control pins
// Assumes: Same ref_clk as the processor; one snoop in flight
// Notes: Data bus sharing with the processor is not arbitrated here
`timescale 1ns/1ps
`include "csb_defines.svh"
module csb_agent (
	input wire logic ref_clk,
	input wire logic sys_rst,
	csb_if.agt bus,
	input wire logic flush_req,
	input wire logic ignore_req,
	input wire logic init_req,
	input wire logic restart_req,
	input wire logic [1:0] irq_drive,
	input wire logic io_write,
	input wire logic snoop_go,
	input wire logic [`CSB_IDX_W-1:0] snoop_line,
	input wire logic prio_want,
	input wire logic tx_valid,
	input wire logic [`CSB_DATA_W-1:0] tx_data,
	output logic snoop_done,
	output logic snoop_hit,
	output logic snoop_modified,
	output logic prio_granted,
	output logic rx_valid,
	output logic [`CSB_DATA_W-1:0] rx_data,
	output logic nmi_out,
	output logic flush_acked,
	output logic float_fault_seen,
	output logic internal_fault_seen
);
	logic flush_n_r, ign_n_r, init_n_r, rst_n_r, target_ready_strobe_n_r, priority_agent_request_n_r;
	logic [1:0] irq_r; // Local interrupt pin drive
	logic probe_r; // Snoop request pulse
	csb_pkg::csb_idx_t probe_idx_r; // Snoop line
	logic wait_r; // Snoop answer awaited
	logic [1:0] wait_cnt_r; // Cycles until answer is due
	logic dvs_oe_r, dat_oe_r; // Data phase drive
	csb_pkg::csb_data_t dat_o_r; // Data drive value

	// ----------------------------------------
	// Sideband drive
	// ----------------------------------------
	// Levels and target ready leave on the same edge, so the level
	// is already valid when the processor sees target ready
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ign_n_r <= `CSB_PIN_IDLE;
			rst_n_r <= `CSB_PIN_IDLE;
			target_ready_strobe_n_r <= `CSB_PIN_IDLE;
			irq_r <= 2'h0;
		end else begin
			ign_n_r <= ~ignore_req;
			rst_n_r <= ~restart_req;
			target_ready_strobe_n_r <= ~io_write;
			irq_r <= irq_drive;
		end
	end

	// No reset: strap levels must stand across the reset release
	always_ff @(posedge ref_clk) begin
		flush_n_r <= ~flush_req;
		init_n_r <= ~init_req;
	end

	// ----------------------------------------
	// Priority request
	// ----------------------------------------
	// Ownership is taken only with lock released
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			priority_agent_request_n_r <= `CSB_PIN_IDLE;
			prio_granted <= 1'b0;
		end else begin
			priority_agent_request_n_r <= ~prio_want;
			prio_granted <= prio_want & ~priority_agent_request_n_r &
				bus.atomic_seq_n;
		end
	end

	// ----------------------------------------
	// Snoop request and answer
	// ----------------------------------------
	// Both results low is a stall: keep waiting, not an answer
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			probe_r <= 1'b0;
			probe_idx_r <= '0;
			wait_r <= 1'b0;
			wait_cnt_r <= 2'h0;
			snoop_done <= 1'b0;
			snoop_hit <= 1'b0;
			snoop_modified <= 1'b0;
		end else begin
			probe_r <= snoop_go & ~wait_r;
			snoop_done <= 1'b0;
			if (snoop_go && !wait_r) begin
				probe_idx_r <= snoop_line;
				wait_r <= 1'b1;
				wait_cnt_r <= `CSB_SNP_WAIT;
			end else if (wait_cnt_r != 2'h0) begin
				wait_cnt_r <= wait_cnt_r - 2'h1;
			end else if (wait_r && !(~bus.snoop_hit_result_n &&
				~bus.snoop_modified_result_n)) begin
				wait_r <= 1'b0;
				snoop_done <= 1'b1;
				snoop_hit <= ~(bus.snoop_hit_result_n &
					bus.snoop_modified_result_n);
				snoop_modified <= ~bus.snoop_modified_result_n;
			end
		end
	end

	// ----------------------------------------
	// Data bus
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dvs_oe_r <= 1'b0;
			dat_oe_r <= 1'b0;
			dat_o_r <= '1;
			rx_valid <= 1'b0;
			rx_data <= '0;
		end else begin
			dvs_oe_r <= tx_valid;
			dat_oe_r <= tx_valid;
			dat_o_r <= ~tx_data;
			rx_valid <= ~bus.data_valid_strobe_n & ~dvs_oe_r;
			if (~bus.data_valid_strobe_n & ~dvs_oe_r) begin
				rx_data <= ~bus.data_bus_n;
			end
		end
	end

	// ----------------------------------------
	// Processor reports
	// ----------------------------------------
	// Shutdown becomes a one-cycle nmi toward the system
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			nmi_out <= 1'b0;
			flush_acked <= 1'b0;
			float_fault_seen <= 1'b0;
			internal_fault_seen <= 1'b0;
		end else begin
			nmi_out <= bus.shutdown_txn;
			flush_acked <= bus.flush_ack_txn;
			float_fault_seen <= ~bus.float_fault_out_n;
			internal_fault_seen <= ~bus.internal_fault_out_n;
		end
	end

	assign bus.cache_flush_req_n = flush_n_r;
	assign bus.numeric_fault_ignore_n = ign_n_r;
	assign bus.warm_init_n = init_n_r;
	assign bus.bus_fault_restart_n = rst_n_r;
	assign bus.local_irq_pins = irq_r;
	assign bus.target_ready_strobe_n = target_ready_strobe_n_r;
	assign bus.priority_agent_request_n = priority_agent_request_n_r;
	assign bus.snoop_probe = probe_r;
	assign bus.snoop_idx = probe_idx_r;
	assign bus.dvs_agt_o = 1'b0;
	assign bus.dvs_agt_oe = dvs_oe_r;
	assign bus.dat_agt_o = dat_o_r;
	assign bus.dat_agt_oe = dat_oe_r;
endmodule

// file: verification/csb_props.sv
// Purpose: Assertions on the pins joining both ends
// Assumes: One clock, reset active high
// Notes: Sees interface signals only
`timescale 1ns/1ps
module csb_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic dvs_dev_oe,
	input wire logic data_valid_strobe_n,
	input wire logic snoop_hit_result_n,
	input wire logic snoop_modified_result_n,
	input wire logic internal_fault_out_n,
	input wire logic shutdown_txn,
	input wire logic flush_ack_txn,
	input wire logic cache_flush_req_n,
	input wire logic warm_init_n,
	input wire logic bus_fault_restart_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// No clear source lately; slack covers the init synchroniser
	sequence s_no_clear;
		bus_fault_restart_n && $past(bus_fault_restart_n) && warm_init_n &&
			$past(warm_init_n) && $past(warm_init_n, 2) &&
			$past(warm_init_n, 3);
	endsequence
	a_strobe_own: assert property (
		dvs_dev_oe |-> !data_valid_strobe_n) else $error("strobe not low");
	a_strobe_flush: assert property (
		dvs_dev_oe |-> $past(!cache_flush_req_n, 3))
		else $error("write-back without flush request");
	a_mod_hit: assert property (
		!snoop_modified_result_n && snoop_hit_result_n |=>
		snoop_hit_result_n && snoop_modified_result_n)
		else $error("modified result not one cycle");
	a_result_once: assert property (
		!snoop_hit_result_n && snoop_modified_result_n |=>
		snoop_hit_result_n && snoop_modified_result_n)
		else $error("clean result not one cycle");
	a_internal_fault_out_hold: assert property (
		!internal_fault_out_n ##0 s_no_clear |=> !internal_fault_out_n)
		else $error("internal fault dropped early");
	a_internal_fault_out_down: assert property (
		$fell(internal_fault_out_n) |-> shutdown_txn)
		else $error("fault without shutdown");
	a_ack_late: assert property (
		flush_ack_txn |-> $past(!cache_flush_req_n, 10))
		else $error("acknowledge too early");
	a_ack_pulse: assert property (
		flush_ack_txn |=> !flush_ack_txn) else $error("acknowledge too long");
endmodule

// file: verification/tb.sv
// Purpose: Self-checking bench joining both ends of the pins
// Assumes: Inputs move on the falling edge
// Notes: Driver queues expected results, a monitor checks them
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] DIRTY = 8'h26; // Lines made modified
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic fill_valid, store_valid, wb_pause, fp_err_pending, lock_hold;
	logic fp_noncontrol_issue, native_numeric_fault_mode, internal_error;
	logic irq_ctrl_wr, irq_ctrl_en_val, fp_exception, int_regs_reset;
	logic reset_vector_sel, bist_running, maskable_irq, nmi_req;
	logic flush_busy, rx_valid, a_rxv, flush_req, ignore_req, init_req;
	logic restart_req, io_write, snoop_go, prio_want, tx_valid, nmi_out;
	logic snoop_done, snoop_hit, snoop_modified, prio_granted;
	logic flush_acked, float_fault_seen, internal_fault_seen;
	logic [1:0] local_irq_lvl, irq_drive;
	logic [1:0] q_s[$];
	csb_pkg::csb_idx_t fill_idx, store_idx, snoop_line;
	csb_pkg::csb_data_t fill_data, store_data, rx_data, a_rxd, tx_data;
	csb_pkg::csb_data_t q_a[$], q_d[$];
	int error_cnt = 0;
	int checks_done = 0;
	int i;
	// ----------------------------------------
	// Both ends face each other on one carrier
	// ----------------------------------------
	csb_if bus();
	csb_device u_csb_device (.*);
	csb_agent u_csb_agent (.*, .rx_valid(a_rxv), .rx_data(a_rxd));
	csb_props u_csb_props (.ref_clk, .sys_rst, .dvs_dev_oe(bus.dvs_dev_oe),
		.data_valid_strobe_n(bus.data_valid_strobe_n),
		.snoop_hit_result_n(bus.snoop_hit_result_n),
		.snoop_modified_result_n(bus.snoop_modified_result_n),
		.internal_fault_out_n(bus.internal_fault_out_n),
		.shutdown_txn(bus.shutdown_txn), .flush_ack_txn(bus.flush_ack_txn),
		.cache_flush_req_n(bus.cache_flush_req_n),
		.warm_init_n(bus.warm_init_n),
		.bus_fault_restart_n(bus.bus_fault_restart_n));
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk_w(input csb_pkg::csb_data_t g, e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic chk_f(input logic [1:0] g, e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	// One probe at a time; wait is bounded
	task automatic snoop(input int l, input logic [1:0] e);
		q_s.push_back(e);
		snoop_line = l[2:0];
		snoop_go = 1'b1;
		cyc(1);
		snoop_go = 1'b0;
		repeat (60) if (snoop_done !== 1'b1) cyc(1);
		cyc(1);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Results matched in arrival order
	always @(negedge ref_clk) begin
		if (a_rxv === 1'b1)
			chk_w(a_rxd, q_a.pop_front());
		if (rx_valid === 1'b1)
			chk_w(rx_data, q_d.pop_front());
		if (snoop_done === 1'b1)
			chk_f({snoop_hit, snoop_modified}, q_s.pop_front());
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		stop_test;
	end
	initial begin
		{fill_valid, store_valid, wb_pause, fp_err_pending, lock_hold} = '0;
		{fp_noncontrol_issue, native_numeric_fault_mode, internal_error} = '0;
		{irq_ctrl_wr, irq_ctrl_en_val, flush_req, ignore_req, io_write} = '0;
		{restart_req, irq_drive, snoop_go, snoop_line, prio_want} = '0;
		{tx_valid, fill_idx, store_idx, fill_data, store_data, tx_data} = '0;
		{init_req, flush_req} = 2'h3; // Strapped across release
		i = $urandom(35536);
		cyc(8);
		sys_rst = 1'b0;
		cyc(2);
		chk_f({reset_vector_sel, bist_running}, 2'h3);
		flush_req = 1'b0;
		cyc(18);
		chk_f({init_req, bist_running}, 2'h2);
		init_req = 1'b0;
		$display("done straps");
		// Fill every line, then dirty the masked ones
		for (i = 0; i < 16; i++) begin
			fill_valid = !i[3];
			fill_idx = i[2:0];
			fill_data = {$urandom, $urandom};
			store_valid = i[3] & DIRTY[i[2:0]];
			store_idx = i[2:0];
			store_data = {$urandom, $urandom};
			if (store_valid)
				q_a.push_back(store_data);
			cyc(1);
		end
		init_req = 1'b1;
		cyc(4);
		chk_f({int_regs_reset, flush_busy}, 2'h2);
		snoop(0, 2'h2);
		snoop(1, 2'h3);
		init_req = 1'b0;
		$display("done init");
		flush_req = 1'b1;
		repeat (200) if (flush_acked !== 1'b1) begin
			wb_pause = 1'($urandom);
			cyc(1);
		end
		chk_f({flush_acked, flush_busy}, 2'h3);
		wb_pause = 1'b0;
		fill_valid = 1'b1; // Refused while request held
		fill_idx = 3'h3;
		cyc(1);
		fill_valid = 1'b0;
		flush_req = 1'b0;
		cyc(4);
		snoop(3, 2'h0);
		snoop(1, 2'h0);
		chk_w(64'(q_a.size()), '0);
		$display("done flush");
		for (i = 0; i < 6; i++) begin
			tx_valid = i != 3; // One idle clock mid-burst
			tx_data = {$urandom, $urandom};
			if (tx_valid)
				q_d.push_back(tx_data);
			cyc(1);
		end
		tx_valid = 1'b0;
		cyc(4);
		chk_w(64'(q_d.size()), '0);
		internal_error = 1'b1;
		cyc(1);
		internal_error = 1'b0;
		cyc(1);
		chk_f({nmi_out, internal_fault_seen}, 2'h3);
		cyc(11);
		chk_f({internal_fault_seen, restart_req}, 2'h2);
		restart_req = 1'b1;
		cyc(3);
		restart_req = 1'b0;
		cyc(4);
		chk_f({internal_fault_seen, restart_req}, 2'h0);
		fp_err_pending = 1'b1;
		for (i = 0; i < 4; i++) begin
			{native_numeric_fault_mode, ignore_req} = i[1:0];
			io_write = 1'b1;
			cyc(1);
			io_write = 1'b0;
			cyc(4);
			fp_noncontrol_issue = 1'b1;
			cyc(1);
			fp_noncontrol_issue = 1'b0;
			chk_f({float_fault_seen, fp_exception}, {1'b1, i[1] | !i[0]});
		end
		irq_drive = 2'($urandom);
		cyc(6);
		chk_f(local_irq_lvl, irq_drive);
		irq_ctrl_wr = 1'b1;
		cyc(1);
		irq_ctrl_wr = 1'b0;
		cyc(3);
		chk_f({nmi_req, maskable_irq}, irq_drive);
		lock_hold = 1'b1;
		prio_want = 1'b1;
		cyc(6);
		chk_f({prio_granted, lock_hold}, 2'h1);
		lock_hold = 1'b0;
		cyc(6);
		chk_f({prio_granted, lock_hold}, 2'h2);
		chk_w(64'(q_s.size()), '0);
		$display("done side pins");
		stop_test;
	end
endmodule
